// ---- shared/clhp_pkg.sv ----
// Constants, field positions and carrier types of the display host port
package clhp_pkg;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_NS = 5;
    localparam int EXEC_NS = 18500;
    localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOME_NS = 760000;
    localparam int HOME_CYC = (HOME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 18;
    localparam int FIFO_DEPTH = 4;
    // ********************************
    // Interface select and memory map
    // ********************************
    localparam logic [1:0] IF_PARALLEL = 2'h0;
    localparam logic [6:0] DD_SIZE = 7'h50;
    localparam logic [6:0] LINE_LEN = 7'h28;
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [6:0] ONE_LAST = 7'h4F;
    localparam logic [7:0] BLANK_CODE = 8'h20;
    // ********************************
    // Instruction fields
    // ********************************
    localparam int OP_DDA = 7;
    localparam int OP_CGA = 6;
    localparam int OP_FUNC = 5;
    localparam int OP_SHIFT = 4;
    localparam int OP_ENTRY = 2;
    localparam int OP_HOME = 1;
    localparam int OP_CLEAR = 0;
    localparam int FN_DL = 4;
    localparam int FN_N = 3;
    localparam int SH_SC = 3;
    localparam int SH_RL = 2;
    localparam int EN_ID = 1;
    localparam int EN_S = 0;
    // ********************************
    // Reset values
    // ********************************
    localparam logic RST_DL = 1'b1;
    localparam logic RST_LINES = 1'b0;
    localparam logic RST_ID = 1'b1;
    // ********************************
    // Carriers
    // ********************************
    typedef struct packed {
        logic if_hi;
        logic if_lo;
        logic rs;
        logic rw;
        logic e;
        logic [7:0] db;
    } clhp_pins_t;
    typedef struct packed {
        logic to_glyph;
        logic [6:0] addr;
        logic [7:0] data;
    } clhp_wr_t;
endpackage

// ---- rtl/clhp_port.sv ----
// Parallel host port of a character display controller with RAM write FIFO
//
// Overview of operation
// R1: Interface pins pick parallel; width bit picks 4/8
// R2: Instruction and data holding registers, eight bits
// R3: Data read prefetches next RAM location
// R4: Data write goes to RAM automatically
// R5: Target RAM follows last address instruction
// R6: Instruction register never readable by host
// R7: Select 0, write 0 takes instruction
// R8: Select 0, read 1 returns busy and pointer
// R9: Select 1, write 0 fills data register
// R10: Select 1, read 1 returns data register
// R11: Busy high refuses new instructions
// R12: Host polls busy before every instruction
// R13: Busy read only on parallel interfaces
// R14: Text RAM holds eighty eight-bit codes
// R15: Code selects one of 256 glyphs
// R16: One-line mode shows from head address
// R17: Two-line map 00-27 and 40-67
// R18: Sixteen columns show 00-0F and 40-4F
// R19: Display shift offsets both lines by one
// R20: Pointer steps after each RAM access
// R21: Four-bit mode moves high nibble first

// ********************************
// Write FIFO
// ********************************
module clhp_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input logic mclk,
    input logic reset,
    input logic clk_en,
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Full and empty straight from the fill count
    assign in_ready = cnt_reg != (AW+1)'(D);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers wrap naturally, depth is a power of two
    always_ff @(posedge mclk) begin
        if (reset) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage is not reset, only pointers matter
    always_ff @(posedge mclk) begin
        if (clk_en && push) mem[wp_reg] <= in_data;
    end
endmodule

// ********************************
// Host port top
// ********************************
module clhp_port import clhp_pkg::*; #(
    parameter int HOME_CYCLES = HOME_CYC
) (
    input logic mclk,
    input logic reset,
    input logic clk_en,
    input logic interface_select_hi,
    input logic interface_select_lo,
    input logic register_select,
    input logic read_write,
    input logic enable,
    input logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic db_oe,
    input logic view_line,
    input logic [6:0] view_pos,
    output logic [6:0] view_addr,
    output logic [7:0] view_code,
    output logic view_user_glyph,
    output logic busy_indicator
);
    clhp_pins_t pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
    logic e_prev_reg, e_rise, e_fall, par, done;
    logic nib_reg, bus_width_bit_reg, lines_reg, id_reg, es_reg;
    logic glyph_reg, clr_reg, pf_reg, pf_do, ins_acc, dwr, dwr_ok, drd;
    logic [3:0] hi_nib_reg;
    logic [7:0] wbyte, rd_val, instruction_holding_register_reg;
    logic [7:0] data_holding_register_reg, db_out_reg;
    logic db_oe_reg;
    logic [6:0] address_pointer_reg, offset_reg, clr_idx_reg;
    logic [CNT_W-1:0] busy_cnt_reg;
    logic [7:0] display_text_ram [80];
    logic [7:0] user_glyph_ram [64];
    logic fifo_rdy, fifo_ov;
    clhp_wr_t fifo_in, fifo_out;
    logic [7:0] col, vidx;
    logic [6:0] vlast;
    logic [6:0] view_addr_reg;
    logic [7:0] view_code_reg;
    logic view_user_glyph_reg;

    function automatic logic [6:0] ac_step(input logic [6:0] a,
        input logic up, input logic g, input logic two);
        if (g) return {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
        if (two && up) return a == LINE1_LAST ? LINE2_BASE :
            (a == LINE2_LAST ? 7'h00 : a + 7'h01);
        if (two) return a == 7'h00 ? LINE2_LAST :
            (a == LINE2_BASE ? LINE1_LAST : a - 7'h01);
        if (up) return a == ONE_LAST ? 7'h00 : a + 7'h01;
        return a == 7'h00 ? ONE_LAST : a - 7'h01;
    endfunction

    function automatic logic [6:0] off_step(input logic [6:0] o,
        input logic up, input logic two);
        logic [6:0] last;
        last = two ? LINE1_LAST : ONE_LAST;
        if (up) return o == last ? 7'h00 : o + 7'h01;
        return o == 7'h00 ? last : o - 7'h01;
    endfunction

    // Second line lives above the first forty cells
    function automatic logic [6:0] dd_idx(input logic [6:0] a,
        input logic two);
        return (two && a >= LINE2_BASE) ? a - LINE2_BASE + LINE_LEN : a;
    endfunction

    // ********************************
    // Pin synchronisers
    // ********************************
    assign pin_raw = {interface_select_hi, interface_select_lo,
        register_select, read_write, enable, db_in};

    // A bit only moves once stages two and three agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
            e_prev_reg <= 1'b0;
        end else if (clk_en) begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg))
                | (pin_reg & (s2_reg ^ s3_reg));
            e_prev_reg <= pin_reg.e;
        end
    end

    // Serial modes leave the parallel pins dead
    assign par = {pin_reg.if_hi, pin_reg.if_lo} == IF_PARALLEL; // R1 R13
    assign e_rise = clk_en & par & pin_reg.e & ~e_prev_reg;
    assign e_fall = clk_en & par & ~pin_reg.e & e_prev_reg;
    assign done = e_fall & (bus_width_bit_reg | nib_reg); // R1 R21
    assign wbyte = bus_width_bit_reg ? pin_reg.db
        : {hi_nib_reg, pin_reg.db[7:4]}; // R21
    assign busy_indicator = busy_cnt_reg != '0 | clr_reg | ~fifo_rdy
        | pf_reg;
    assign ins_acc = done & ~pin_reg.rs & ~pin_reg.rw
        & ~busy_indicator; // R7 R11
    assign dwr = done & pin_reg.rs & ~pin_reg.rw;
    assign dwr_ok = dwr & fifo_rdy;
    assign drd = done & pin_reg.rs & pin_reg.rw;

    // ********************************
    // Bus cycles and nibble pairing
    // ********************************
    // Status never exposes the instruction byte
    assign rd_val = pin_reg.rs ? data_holding_register_reg
        : {busy_indicator, address_pointer_reg}; // R6 R8 R10

    // Output data latched at the enable rise, held until its fall
    always_ff @(posedge mclk) begin
        if (reset) begin
            nib_reg <= 1'b0;
            hi_nib_reg <= 4'h0;
            db_out_reg <= 8'h00;
            db_oe_reg <= 1'b0;
        end else if (clk_en) begin
            if (e_rise && pin_reg.rw) begin
                db_oe_reg <= 1'b1;
                if (bus_width_bit_reg) db_out_reg <= rd_val; // R8 R10
                else if (nib_reg) db_out_reg <= {rd_val[3:0], 4'h0}; // R21
                else db_out_reg <= {rd_val[7:4], 4'h0}; // R21
            end
            if (e_fall || !par) db_oe_reg <= 1'b0; // R13
            if (e_fall && !bus_width_bit_reg) begin
                nib_reg <= ~nib_reg; // R21
                if (!nib_reg) hi_nib_reg <= pin_reg.db[7:4];
            end
            if (ins_acc && wbyte[OP_FUNC] && wbyte[7:6] == 2'h0)
                nib_reg <= 1'b0;
        end
    end
    assign db_out = db_out_reg;
    assign db_oe = db_oe_reg;

    // Instruction holding register, write only
    always_ff @(posedge mclk) begin
        if (reset) instruction_holding_register_reg <= 8'h00;
        else if (ins_acc) instruction_holding_register_reg <= wbyte; // R2 R7
    end

    // ********************************
    // Instruction decode and pointer
    // ********************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            address_pointer_reg <= 7'h00;
            offset_reg <= 7'h00;
            glyph_reg <= 1'b0;
            bus_width_bit_reg <= RST_DL;
            lines_reg <= RST_LINES;
            id_reg <= RST_ID;
            es_reg <= 1'b0;
        end else if (ins_acc) begin
            if (wbyte[OP_DDA]) begin
                address_pointer_reg <= wbyte[6:0];
                glyph_reg <= 1'b0; // R5
            end else if (wbyte[OP_CGA]) begin
                address_pointer_reg <= {1'b0, wbyte[5:0]};
                glyph_reg <= 1'b1; // R5
            end else if (wbyte[OP_FUNC]) begin
                bus_width_bit_reg <= wbyte[FN_DL]; // R1
                lines_reg <= wbyte[FN_N];
                offset_reg <= 7'h00;
            end else if (wbyte[OP_SHIFT]) begin
                if (wbyte[SH_SC]) offset_reg <= off_step(offset_reg,
                    ~wbyte[SH_RL], lines_reg); // R19
                else address_pointer_reg <= ac_step(address_pointer_reg,
                    wbyte[SH_RL], glyph_reg, lines_reg);
            end else if (wbyte[OP_ENTRY]) begin
                id_reg <= wbyte[EN_ID];
                es_reg <= wbyte[EN_S];
            end else if (wbyte[OP_HOME] || wbyte[OP_CLEAR]) begin
                address_pointer_reg <= 7'h00;
                offset_reg <= 7'h00;
                glyph_reg <= 1'b0;
                if (!wbyte[OP_HOME]) id_reg <= RST_ID;
            end
        end else if (dwr_ok || drd) begin
            address_pointer_reg <= ac_step(address_pointer_reg, id_reg,
                glyph_reg, lines_reg); // R20
            if (dwr_ok && es_reg)
                offset_reg <= off_step(offset_reg, id_reg, lines_reg);
        end
    end

    // Busy time: clear, home and code 00 are long, the rest short
    always_ff @(posedge mclk) begin
        if (reset) busy_cnt_reg <= '0;
        else if (ins_acc && wbyte[7:2] == 6'h00)
            busy_cnt_reg <= CNT_W'(HOME_CYCLES); // R11
        else if (ins_acc || dwr_ok || drd)
            busy_cnt_reg <= CNT_W'(EXEC_CYC);
        else if (clk_en && busy_cnt_reg != '0)
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
    end

    // Blanking walks the whole text RAM one cell a cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            clr_reg <= 1'b0;
            clr_idx_reg <= 7'h00;
        end else if (ins_acc && wbyte == 8'h01) begin
            clr_reg <= 1'b1;
            clr_idx_reg <= 7'h00;
        end else if (clk_en && clr_reg) begin
            clr_idx_reg <= clr_idx_reg + 7'h01;
            if (clr_idx_reg == DD_SIZE - 7'h01) clr_reg <= 1'b0;
        end
    end

    // ********************************
    // Data register, FIFO and RAM
    // ********************************
    assign fifo_in = '{to_glyph: glyph_reg, addr: address_pointer_reg,
        data: wbyte};
    // Reading must wait for queued writes so it sees fresh data
    assign pf_do = clk_en & pf_reg & ~fifo_ov & ~clr_reg;

    clhp_fifo #(.W($bits(clhp_wr_t)), .D(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(dwr), // R4
        .in_ready(fifo_rdy),
        .in_data(fifo_in),
        .out_valid(fifo_ov),
        .out_ready(~clr_reg),
        .out_data(fifo_out)
    );

    // Pending fetch: a new request beats the completion
    always_ff @(posedge mclk) begin
        if (reset) pf_reg <= 1'b0;
        else pf_reg <= (pf_reg & ~pf_do) | drd
            | (ins_acc & (wbyte[OP_DDA] | wbyte[OP_CGA])); // R3
    end

    always_ff @(posedge mclk) begin
        if (reset) data_holding_register_reg <= 8'h00;
        else if (dwr) data_holding_register_reg <= wbyte; // R9
        else if (pf_do) data_holding_register_reg <= glyph_reg
            ? user_glyph_ram[address_pointer_reg[5:0]]
            : display_text_ram[dd_idx(address_pointer_reg, lines_reg)]; // R3
    end

    // Clear has priority; the FIFO stalls meanwhile
    always_ff @(posedge mclk) begin
        if (clk_en && clr_reg) display_text_ram[clr_idx_reg] <= BLANK_CODE;
        else if (clk_en && fifo_ov) begin
            if (fifo_out.to_glyph)
                user_glyph_ram[fifo_out.addr[5:0]] <= fifo_out.data; // R5
            else if (dd_idx(fifo_out.addr, lines_reg) < DD_SIZE)
                display_text_ram[dd_idx(fifo_out.addr, lines_reg)]
                    <= fifo_out.data; // R4 R14
        end
    end

    // ********************************
    // Display position map
    // ********************************
    assign vlast = lines_reg ? LINE1_LAST : ONE_LAST; // R16 R17
    always_comb begin
        col = {1'b0, view_pos} + {1'b0, offset_reg}; // R19
        if (col > {1'b0, vlast}) col = col - {1'b0, vlast} - 8'h01;
        vidx = (lines_reg && view_line) ? col + {1'b0, LINE_LEN} : col;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            view_addr_reg <= 7'h00;
            view_code_reg <= 8'h00;
            view_user_glyph_reg <= 1'b0;
        end else if (clk_en) begin
            view_addr_reg <= (lines_reg && view_line)
                ? LINE2_BASE + col[6:0] : col[6:0]; // R17 R18
            view_code_reg <= vidx < {1'b0, DD_SIZE}
                ? display_text_ram[vidx[6:0]] : BLANK_CODE;
            view_user_glyph_reg <= vidx < {1'b0, DD_SIZE}
                && display_text_ram[vidx[6:0]][7:4] == 4'h0; // R15
        end
    end
    assign view_addr = view_addr_reg;
    assign view_code = view_code_reg;
    assign view_user_glyph = view_user_glyph_reg;

    // ********************************
    // Checks
    // ********************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    chk_status_read: assert property (e_rise && !pin_reg.rs && pin_reg.rw // R8
        && bus_width_bit_reg |=> db_out == {$past(busy_indicator),
        $past(address_pointer_reg)} && db_oe)
        else $error("status read wrong");
    chk_data_read: assert property (e_rise && pin_reg.rs && pin_reg.rw // R10
        && bus_width_bit_reg |=> db_out == $past(data_holding_register_reg))
        else $error("data read wrong");
    chk_instr_take: assert property (ins_acc // R7
        |=> instruction_holding_register_reg == $past(wbyte))
        else $error("instruction not taken");
    chk_busy_refuse: assert property (done && !pin_reg.rs && !pin_reg.rw // R11
        && busy_indicator |=> $stable(instruction_holding_register_reg))
        else $error("instruction taken while busy");
    chk_data_write: assert property (dwr && fifo_rdy |=> fifo_ov // R4
        && data_holding_register_reg == $past(wbyte))
        else $error("data write lost");
    chk_serial_quiet: assert property (!par |=> !db_oe) // R13
        else $error("bus driven in serial mode");
    chk_nibble_pair: assert property (e_fall && !bus_width_bit_reg // R21
        && !nib_reg && !ins_acc |=> nib_reg && !$stable(nib_reg))
        else $error("nibble order wrong");
    chk_pointer_step: assert property (drd && !glyph_reg && id_reg // R20
        && !lines_reg && address_pointer_reg == ONE_LAST
        |=> address_pointer_reg == 7'h00)
        else $error("pointer wrap wrong");
    chk_pointer_inc: assert property (drd && !glyph_reg && id_reg // R20
        && address_pointer_reg < LINE1_LAST
        |=> address_pointer_reg == $past(address_pointer_reg) + 7'h01)
        else $error("pointer step wrong");
    chk_prefetch_wait: assert property (pf_reg && fifo_ov // R3
        |=> pf_reg) else $error("fetch ran before writes drained");
    chk_shift_wrap: assert property (clk_en && lines_reg && !view_line // R19
        && view_pos == 7'h00 && offset_reg == LINE1_LAST
        |=> view_addr == LINE1_LAST) else $error("right shift wrap wrong");

    cov_nibble_read: cover property (drd && !bus_width_bit_reg);
    cov_fifo_full: cover property (dwr && !fifo_rdy);
    cov_clear_done: cover property (clr_reg ##1 !clr_reg);
    cov_glyph_write: cover property (dwr_ok && glyph_reg);
endmodule

// ---- sim/clhp_host.sv ----
// Host processor model that drives the parallel bus of the display port
module clhp_host (
    input wire logic mclk,
    input wire logic [7:0] db_out,
    input wire logic db_oe,
    output logic register_select,
    output logic read_write,
    output logic enable,
    output logic [7:0] db_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************
    // Bus state
    // ********************************
    // Width the host believes the port uses; follows its own function sets
    logic four;

    // Idle bus at time zero
    initial begin
        register_select = 1'b0;
        read_write = 1'b0;
        enable = 1'b0;
        db_in = 8'h00;
        four = 1'b0;
    end

    // ********************************
    // Bus cycles
    // ********************************
    // One strobe; phases are long enough to clear the port's pin filter.
    // During reads the host keeps driving, putting the inverse of its previous db_in value on the line.
    task automatic phase(input logic rs, input logic rw, input logic [7:0] wd,
                         output logic [7:0] rd, output logic oe);
        @(posedge mclk);
        register_select <= rs;
        read_write <= rw;
        db_in <= rw ? ~db_in : wd;
        repeat (6) @(posedge mclk);
        enable <= 1'b1;
        repeat (8) @(posedge mclk);
        rd = db_out;
        oe = db_oe;
        enable <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // Whole byte; narrow mode carries the high nibble first on db[7:4]
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd,
                        output logic [7:0] rd, output logic oe);
        logic [7:0] h;
        logic oh;
        if (four) begin
            phase(rs, rw, {wd[7:4], ~wd[7:4]}, h, oh);
            phase(rs, rw, {wd[3:0], ~wd[3:0]}, rd, oe);
            rd = {h[7:4], rd[7:4]};
            oe = oe | oh;
        end else begin
            phase(rs, rw, wd, rd, oe);
        end
    endtask

    // Instruction only after status shows the port idle; bounded poll
    task automatic instr(input logic [7:0] code, output logic ok);
        logic [7:0] st;
        logic oe;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            xfer(1'b0, 1'b1, 8'h00, st, oe);
            ok = (st[7] === 1'b0);
        end
        if (ok) begin
            xfer(1'b0, 1'b0, code, st, oe);
            if (code[7:5] == 3'b001) begin
                four = ~code[4];
            end
        end
    endtask
endmodule

// ---- sim/char_lcd_host_port_display_text_ram_map_tb.sv ----
// Self-checking bench for the display host port and its text RAM map
module char_lcd_host_port_display_text_ram_map_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************
    // Signals and instances
    // ********************************
    logic mclk;
    logic reset = 1'b1;
    logic interface_select_hi = 1'b0;
    logic interface_select_lo = 1'b0;
    logic view_line = 1'b0;
    logic [6:0] view_pos = 7'h00;
    logic register_select;
    logic read_write;
    logic enable;
    logic [7:0] db_in;
    logic [7:0] db_out;
    logic db_oe;
    logic [6:0] view_addr;
    logic [7:0] view_code;
    logic view_user_glyph;
    logic busy_indicator;
    logic [7:0] v;
    logic oe;
    int fails = 0;
    int total_checks = 0;

    // Short home count keeps clear and home waits brief
    clhp_port #(.HOME_CYCLES(200)) u_clhp_port (
        .mclk(mclk), .reset(reset), .clk_en(1'b1),
        .interface_select_hi(interface_select_hi),
        .interface_select_lo(interface_select_lo),
        .register_select(register_select), .read_write(read_write),
        .enable(enable), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
        .view_line(view_line), .view_pos(view_pos),
        .view_addr(view_addr), .view_code(view_code),
        .view_user_glyph(view_user_glyph), .busy_indicator(busy_indicator)
    );

    clhp_host u_clhp_host (
        .mclk(mclk), .db_out(db_out), .db_oe(db_oe),
        .register_select(register_select), .read_write(read_write),
        .enable(enable), .db_in(db_in)
    );

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ********************************
    // Helpers
    // ********************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A poll that never sees idle ends the run as a failure
    task automatic cmd(input logic [7:0] code);
        logic ok;
        u_clhp_host.instr(code, ok);
        if (ok !== 1'b1) begin
            fails++;
            results();
        end
    endtask

    task automatic rd(input logic rs, output logic [7:0] d);
        logic o;
        u_clhp_host.xfer(rs, 1'b1, 8'h00, d, o);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [7:0] x;
        logic o;
        u_clhp_host.xfer(1'b1, 1'b0, d, x, o);
    endtask

    // ********************************
    // View map rows: optional shift instruction, then line and position
    // ********************************
    localparam int NROW = 12;
    logic [7:0] row_pre [NROW] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h18, 8'h00, 8'h00, 8'h1C, 8'h1C, 8'h00};
    logic row_line [NROW] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
        1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [6:0] row_pos [NROW] = '{7'h00, 7'h01, 7'h27, 7'h00, 7'h0F, 7'h27,
        7'h00, 7'h0F, 7'h0F, 7'h00, 7'h00, 7'h00};
    logic [6:0] row_addr [NROW] = '{7'h00, 7'h01, 7'h27, 7'h40, 7'h4F,
        7'h67, 7'h01, 7'h10, 7'h50, 7'h00, 7'h27, 7'h67};
    logic [7:0] row_code [NROW] = '{8'h41, 8'h42, 8'h20, 8'h05, 8'h20,
        8'h20, 8'h42, 8'h20, 8'h20, 8'h41, 8'h20, 8'h20};

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        check(db_out, 8'h00);
        check({7'h00, db_oe}, 8'h00);
        check({7'h00, busy_indicator}, 8'h00);
        rd(1'b0, v);
        check(v, 8'h00);
        // Two lines, clear to blanks, then fill the heads of both lines
        cmd(8'h38);
        cmd(8'h01);
        // Write and read back while blanking stalls the queue and the fetch
        wr(8'h41);
        rd(1'b1, v);
        check(v, 8'h41);
        cmd(8'h80);
        wr(8'h41);
        wr(8'h42);
        check({7'h00, busy_indicator}, 8'h01);
        rd(1'b0, v);
        check(v, 8'h82);
        cmd(8'hC0);
        wr(8'h05);
        for (int r = 0; r < NROW; r++) begin
            if (row_pre[r] != 8'h00) begin
                cmd(row_pre[r]);
            end
            @(posedge mclk);
            view_line <= row_line[r];
            view_pos <= row_pos[r];
            repeat (2) @(posedge mclk);
            #1;
            check({1'b0, view_addr}, {1'b0, row_addr[r]});
            check(view_code, row_code[r]);
            check({7'h00, view_user_glyph},
                  {7'h00, row_code[r][7:4] == 4'h0});
        end
        // Reads prefetch the following cell
        cmd(8'h80);
        rd(1'b1, v);
        check(v, 8'h41);
        rd(1'b1, v);
        check(v, 8'h42);
        // Address instruction sent while busy must be ignored
        u_clhp_host.xfer(1'b0, 1'b0, 8'hC5, v, oe);
        cmd(8'h06);
        rd(1'b0, v);
        check(v, 8'h82);
        // Narrow bus: every byte goes as two nibbles
        cmd(8'h28);
        cmd(8'h83);
        wr(8'h5A);
        rd(1'b0, v);
        check(v, 8'h84);
        cmd(8'h83);
        rd(1'b1, v);
        check(v, 8'h5A);
        // One line: second view line ignored, cells run on past 27
        cmd(8'h20);
        @(posedge mclk);
        view_line <= 1'b1;
        view_pos <= 7'h28;
        repeat (2) @(posedge mclk);
        #1;
        check({1'b0, view_addr}, 8'h28);
        check(view_code, 8'h05);
        // Read at the last one-line cell wraps the pointer to the head
        cmd(8'hCF);
        rd(1'b1, v);
        check(v, 8'h20);
        rd(1'b0, v);
        check(v, 8'h80);
        // Serial strap: parallel reads must leave the bus alone
        @(posedge mclk);
        interface_select_lo <= 1'b1;
        repeat (8) @(posedge mclk);
        u_clhp_host.xfer(1'b0, 1'b1, 8'h00, v, oe);
        check({7'h00, oe}, 8'h00);
        @(posedge mclk);
        interface_select_lo <= 1'b0;
        interface_select_hi <= 1'b1;
        repeat (8) @(posedge mclk);
        u_clhp_host.xfer(1'b0, 1'b1, 8'h00, v, oe);
        check({7'h00, oe}, 8'h00);
        results();
    end
endmodule
